// file: line_modes_regs.vh
// Register offsets, field positions, reset values and timing counts for the line-mode block
`ifndef LINE_MODES_REGS_VH
`define LINE_MODES_REGS_VH
// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFF_COMMAND 12'h000
`define OFF_MODE_CONFIG 12'h004
`define OFF_IRQ_ENABLE 12'h008
`define OFF_IRQ_DISABLE 12'h00c
`define OFF_IRQ_MASK 12'h010
`define OFF_CHANNEL_STATUS 12'h014
`define OFF_RX_HOLDING 12'h018
`define OFF_TX_HOLDING 12'h01c
`define OFF_BAUD_DIVIDER 12'h020
`define OFF_RX_TIMEOUT 12'h024
`define OFF_TX_TIMEGUARD 12'h028
`define OFF_CLOCK_RATIO 12'h040
`define OFF_ERROR_COUNT 12'h044
`define OFF_INFRARED_FILTER 12'h04c
`define OFF_LINE_CODE_CONFIG 12'h050
`define OFF_LINE_EVENTS 12'h060
// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_CLOCK_RATIO 11'h174
`define RST_ZERO 32'h00000000
// ----------------------------------------------------------------------------
// Command bits
// ----------------------------------------------------------------------------
`define CMD_RX_RESET 2
`define CMD_TX_RESET 3
`define CMD_RX_ON 4
`define CMD_RX_OFF 5
`define CMD_TX_ON 6
`define CMD_TX_OFF 7
`define CMD_CLR_STATUS 8
`define CMD_BRK_BEGIN 9
`define CMD_BRK_END 10
`define CMD_TO_START 11
`define CMD_SEND_ADDR 12
`define CMD_CLR_ITER 13
`define CMD_CLR_NACK 14
`define CMD_TO_REARM 15
`define CMD_DTR_ON 16
`define CMD_DTR_OFF 17
`define CMD_RTS_ON 18
`define CMD_RTS_OFF 19
// ----------------------------------------------------------------------------
// Mode fields
// ----------------------------------------------------------------------------
`define MODE_OPMODE_LSB 0
`define MODE_CHANNEL_MODE_FIELD_LSB 14
`define MODE_PAR_LSB 9
`define OPMODE_NORMAL 4'h0
`define OPMODE_RS485 4'h1
`define OPMODE_MODEM 4'h3
`define OPMODE_ISO_T0 4'h4
`define OPMODE_ISO_T1 4'h6
`define OPMODE_INFRARED 4'h8
`define CHANNEL_MODE_FIELD_NORMAL 2'h0
`define CHANNEL_MODE_FIELD_ECHO 2'h1
`define CHANNEL_MODE_FIELD_LOCAL 2'h2
`define CHANNEL_MODE_FIELD_REMOTE 2'h3
`define PAR_MULTIDROP 3'h6
// ----------------------------------------------------------------------------
// Status bits
// ----------------------------------------------------------------------------
`define ST_BREAK_RECEIVED_FLAG 2
`define ST_OVERRUN 5
`define ST_FRAME 6
`define ST_PARITY 7
`define ST_TX_EMPTY 9
`define ST_ITERATION 10
`define ST_RING_CHG 16
`define ST_DSR_CHG 17
`define ST_DCD_CHG 18
`define ST_CTS_CHG 19
`define ST_RI_LVL 20
`define ST_DSR_LVL 21
`define ST_DCD_LVL 22
`define ST_CTS_LVL 23
// ----------------------------------------------------------------------------
// Line-event bits (hardware sets these from the character engine)
// ----------------------------------------------------------------------------
`define EV_PARITY 0
`define EV_FRAME 1
`define EV_OVERRUN 2
`define EV_BREAK_RECEIVED_FLAG 3
`define EV_ITERATION 4
// ----------------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------------
`define BRK_MIN_BITS 8'd10
`define BRK_TAIL_BITS 8'd12
`endif

// file: ir_rx_filter.v
// Infrared receive pulse filter with an 8-bit down counter
`timescale 1ns/10ps
module ir_rx_filter (
   input wire clk, // Master clock
   input wire resetn, // Async reset, active low
   input wire enable, // Infrared mode active
   input wire [7:0] filter_value, // Programmed filter length
   input wire rx_pin, // Raw receive line
   input wire bit_tick, // One pulse per bit time
   output reg rx_out // Demodulated receiver input
);
   reg [7:0] count_reg;
   reg running_reg;
   reg rx_prev_reg;
   reg hold_reg;
   wire fall = rx_prev_reg & ~rx_pin;
   wire rise = ~rx_prev_reg & rx_pin;

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         count_reg <= 8'h00;
         running_reg <= 1'b0;
         rx_prev_reg <= 1'b1;
         hold_reg <= 1'b0;
         rx_out <= 1'b1;
      end else begin
         rx_prev_reg <= rx_pin;
         if (!enable) begin
            running_reg <= 1'b0;
            hold_reg <= 1'b0;
            count_reg <= filter_value;
            rx_out <= 1'b1;
         end else begin
            if (hold_reg && bit_tick) begin
               hold_reg <= 1'b0;
            end
            if (rise) begin
               running_reg <= 1'b0;
               count_reg <= filter_value;
            end else if (fall && !running_reg) begin
               running_reg <= 1'b1;
               count_reg <= filter_value;
            end else if (running_reg) begin
               if (count_reg == 8'h00) begin
                  running_reg <= 1'b0;
                  hold_reg <= 1'b1;
                  count_reg <= filter_value;
               end else begin
                  count_reg <= count_reg - 8'h01;
               end
            end
            rx_out <= ~(hold_reg | (running_reg && count_reg == 8'h00));
         end
      end
   end
endmodule // ir_rx_filter

// file: usart_line_modes_ctrl.v
// Line-mode logic, command register and APB register file of the serial channel
`timescale 1ns/10ps
`include "line_modes_regs.vh"
// Operation
// - Infrared filter uses an 8-bit down counter loaded from the filter register.
// - A falling receive edge starts the counter decrementing every clock.
// - A rising edge while counting halts and reloads the counter.
// - Counter reaching zero forces the receiver input low one bit time; the filter holds it low only until the next bit tick.
// - Operating mode 0x1 selects RS485 line-driver control.
// - In RS485 mode RTS is the inverse of transmitter-empty.
// - In RS485 mode RTS stays high through a programmed timeguard.
// - Operating mode 0x3 selects modem mode as terminal equipment.
// - Disable command drives RTS or DTR high, enable drives it low.
// - Modem input changes set sticky flags, cleared when status is read.
// - CTS inactive in modem mode disables transmitter after current character.
// - Normal channel mode: receive pin to receiver, transmitter to transmit pin.
// - Echo mode forwards receive pin to transmit pin, receiver still active.
// - Local loopback: transmitter feeds receiver, transmit pin held high.
// - Remote loopback: receive pin to transmit pin, both engines disabled.
// - Enable commands act only if the matching disable is clear.
// - Clear-status command clears parity, framing, overrun and break flags.
// - Break begins after holding and shift registers drain, not if active.
// - Break end after one character, then 12 bits high; ignored if idle.
// - In multidrop, send-address marks the next written character as address.
// - Clear-iterations clears the iteration flag only in smart-card mode.
// - Operating mode 0x8 selects infrared with demodulator active.
module usart_line_modes_ctrl (
   input wire CLK, // Master clock, 100 MHz
   input wire RESETN, // Async reset, active low
   input wire PSEL, // APB select
   input wire PENABLE, // APB access phase
   input wire PWRITE, // APB direction
   input wire [11:0] PADDR, // APB byte address
   input wire [31:0] PWDATA, // APB write data
   output wire [31:0] PRDATA, // APB read data
   output wire PREADY, // APB ready
   output wire PSLVERR, // APB error on unmapped address
   input wire RXD, // Receive pin
   output reg TXD, // Transmit pin
   output reg RTS, // Request to send, low active in modem
   output reg DTR, // Data terminal ready, low active
   input wire CTS, // Clear to send
   input wire DSR, // Data set ready
   input wire DCD, // Carrier detect
   input wire RI, // Ring indicator
   input wire BIT_TICK, // One pulse per bit time from baud logic
   input wire TX_SERIAL, // Transmitter serial output
   input wire TX_EMPTY, // Holding and shift registers both empty
   input wire TX_CHAR_BUSY, // A character is being shifted out
   input wire TIMEGUARD_BUSY, // Timeguard period running
   input wire [4:0] LINE_EVENTS, // Parity, frame, overrun, break, iteration
   output reg RX_SERIAL, // Receiver serial input
   output reg RX_ENABLE, // Receiver enabled
   output reg TX_ENABLE, // Transmitter enabled
   output reg RX_RESET, // Receiver reset pulse
   output reg TX_RESET, // Transmitter reset pulse
   output reg BREAK_ACTIVE, // Break being driven on line
   output reg ADDR_PENDING, // Next character carries address bit
   output reg TO_START, // Time-out start pulse
   output reg TO_REARM, // Time-out rearm pulse
   output reg NACK_CLEAR, // Clear not-acknowledge pulse
   output reg [31:0] MODE_OUT, // Mode register contents
   output reg [15:0] BAUD_OUT, // Baud divider contents
   output reg [15:0] TIMEOUT_OUT, // Receive time-out contents
   output reg [7:0] TIMEGUARD_OUT, // Timeguard contents
   output reg [10:0] RATIO_OUT // Clock ratio contents
);
   // -------------------------------------------------------------------------
   // Bus decode
   // -------------------------------------------------------------------------
   reg [31:0] irq_mask_reg;
   reg [7:0] filter_reg;
   reg [31:0] line_code_reg;
   reg [10:0] status_reg;
   reg [3:0] chg_reg;
   reg [3:0] modem_prev_reg;
   reg [31:0] rdata;
   reg hit;
   reg rts_cmd_reg;
   reg cts_hold_reg;
   reg [1:0] brk_state_reg;
   reg [7:0] brk_count_reg;
   reg brk_end_pending_reg;
   reg [31:0] prdata_reg;
   reg rx_on_reg;
   reg tx_on_reg;
   wire [3:0] opmode = MODE_OUT[`MODE_OPMODE_LSB+3:`MODE_OPMODE_LSB];
   wire [1:0] channel_mode_field = MODE_OUT[`MODE_CHANNEL_MODE_FIELD_LSB+1:`MODE_CHANNEL_MODE_FIELD_LSB];
   wire smart_card = (opmode == `OPMODE_ISO_T0) || (opmode == `OPMODE_ISO_T1);
   wire multidrop = ((MODE_OUT[`MODE_PAR_LSB+2:`MODE_PAR_LSB] & 3'h6) == `PAR_MULTIDROP);
   wire access = PSEL & PENABLE;
   wire wr = access & PWRITE;
   wire rd = access & ~PWRITE;
   wire wr_cmd = wr && PADDR == `OFF_COMMAND;
   wire [31:0] cmd = wr_cmd ? PWDATA : 32'h00000000;
   wire [3:0] modem_now = {CTS, DCD, DSR, RI};
   wire status_read = rd && PADDR == `OFF_CHANNEL_STATUS;
   wire ir_rx;

   assign PREADY = 1'b1;
   assign PSLVERR = access & ~hit;
   assign PRDATA = prdata_reg;

   always @* begin
      hit = 1'b1;
      rdata = 32'h00000000;
      case (PADDR)
         `OFF_COMMAND, `OFF_IRQ_ENABLE, `OFF_IRQ_DISABLE, `OFF_TX_HOLDING: rdata = 32'h00000000;
         `OFF_MODE_CONFIG: rdata = MODE_OUT;
         `OFF_IRQ_MASK: rdata = irq_mask_reg;
         `OFF_CHANNEL_STATUS: begin
            rdata[`ST_PARITY] = status_reg[`ST_PARITY];
            rdata[`ST_FRAME] = status_reg[`ST_FRAME];
            rdata[`ST_OVERRUN] = status_reg[`ST_OVERRUN];
            rdata[`ST_BREAK_RECEIVED_FLAG] = status_reg[`ST_BREAK_RECEIVED_FLAG];
            rdata[`ST_ITERATION] = status_reg[`ST_ITERATION];
            rdata[`ST_TX_EMPTY] = TX_EMPTY;
            rdata[`ST_CTS_CHG:`ST_RING_CHG] = chg_reg;
            rdata[`ST_CTS_LVL:`ST_RI_LVL] = modem_now;
         end
         `OFF_RX_HOLDING, `OFF_ERROR_COUNT: rdata = 32'h00000000;
         `OFF_BAUD_DIVIDER: rdata = {16'h0000, BAUD_OUT};
         `OFF_RX_TIMEOUT: rdata = {16'h0000, TIMEOUT_OUT};
         `OFF_TX_TIMEGUARD: rdata = {24'h000000, TIMEGUARD_OUT};
         `OFF_CLOCK_RATIO: rdata = {21'h00000, RATIO_OUT};
         `OFF_INFRARED_FILTER: rdata = {24'h000000, filter_reg};
         `OFF_LINE_CODE_CONFIG: rdata = line_code_reg;
         `OFF_LINE_EVENTS: rdata = {27'h000000, LINE_EVENTS};
         default: hit = 1'b0;
      endcase
   end

   // -------------------------------------------------------------------------
   // Read data register, captured in the setup cycle
   // -------------------------------------------------------------------------
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         prdata_reg <= 32'h00000000;
      end else if (PSEL && !PENABLE && !PWRITE) begin
         prdata_reg <= rdata;
      end
   end

   // -------------------------------------------------------------------------
   // Configuration registers
   // -------------------------------------------------------------------------
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         MODE_OUT <= `RST_ZERO;
         irq_mask_reg <= `RST_ZERO;
         BAUD_OUT <= 16'h0000;
         TIMEOUT_OUT <= 16'h0000;
         TIMEGUARD_OUT <= 8'h00;
         RATIO_OUT <= `RST_CLOCK_RATIO;
         filter_reg <= 8'h00;
         line_code_reg <= `RST_ZERO;
      end else if (wr) begin
         case (PADDR)
            `OFF_MODE_CONFIG: MODE_OUT <= PWDATA;
            `OFF_IRQ_ENABLE: irq_mask_reg <= irq_mask_reg | PWDATA;
            `OFF_IRQ_DISABLE: irq_mask_reg <= irq_mask_reg & ~PWDATA;
            `OFF_BAUD_DIVIDER: BAUD_OUT <= PWDATA[15:0];
            `OFF_RX_TIMEOUT: TIMEOUT_OUT <= PWDATA[15:0];
            `OFF_TX_TIMEGUARD: TIMEGUARD_OUT <= PWDATA[7:0];
            `OFF_CLOCK_RATIO: RATIO_OUT <= PWDATA[10:0];
            `OFF_INFRARED_FILTER: filter_reg <= PWDATA[7:0];
            `OFF_LINE_CODE_CONFIG: line_code_reg <= PWDATA;
            default: ;
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // Status flags: set wins over clear
   // -------------------------------------------------------------------------
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         status_reg <= 11'h000;
         chg_reg <= 4'h0;
         modem_prev_reg <= 4'hf;
      end else begin
         modem_prev_reg <= modem_now;
         if (cmd[`CMD_CLR_STATUS]) begin
            status_reg[`ST_PARITY] <= 1'b0;
            status_reg[`ST_FRAME] <= 1'b0;
            status_reg[`ST_OVERRUN] <= 1'b0;
            status_reg[`ST_BREAK_RECEIVED_FLAG] <= 1'b0;
         end
         if (cmd[`CMD_CLR_ITER] && smart_card) begin
            status_reg[`ST_ITERATION] <= 1'b0;
         end
         if (LINE_EVENTS[`EV_PARITY]) status_reg[`ST_PARITY] <= 1'b1;
         if (LINE_EVENTS[`EV_FRAME]) status_reg[`ST_FRAME] <= 1'b1;
         if (LINE_EVENTS[`EV_OVERRUN]) status_reg[`ST_OVERRUN] <= 1'b1;
         if (LINE_EVENTS[`EV_BREAK_RECEIVED_FLAG]) status_reg[`ST_BREAK_RECEIVED_FLAG] <= 1'b1;
         if (LINE_EVENTS[`EV_ITERATION]) status_reg[`ST_ITERATION] <= 1'b1;
         chg_reg <= (status_read ? chg_reg & ~prdata_reg[`ST_CTS_CHG:`ST_RING_CHG] : chg_reg)
            | (modem_now ^ modem_prev_reg);
      end
   end

   // -------------------------------------------------------------------------
   // Command register
   // -------------------------------------------------------------------------
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         rx_on_reg <= 1'b0;
         tx_on_reg <= 1'b0;
         RX_RESET <= 1'b0;
         TX_RESET <= 1'b0;
         TO_START <= 1'b0;
         TO_REARM <= 1'b0;
         NACK_CLEAR <= 1'b0;
         ADDR_PENDING <= 1'b0;
         rts_cmd_reg <= 1'b1;
         DTR <= 1'b1;
         cts_hold_reg <= 1'b0;
      end else begin
         RX_RESET <= cmd[`CMD_RX_RESET];
         TX_RESET <= cmd[`CMD_TX_RESET];
         TO_START <= cmd[`CMD_TO_START];
         TO_REARM <= cmd[`CMD_TO_REARM];
         NACK_CLEAR <= cmd[`CMD_CLR_NACK];
         if (cmd[`CMD_RX_OFF]) rx_on_reg <= 1'b0;
         else if (cmd[`CMD_RX_ON]) rx_on_reg <= 1'b1;
         if (cmd[`CMD_TX_OFF]) tx_on_reg <= 1'b0;
         else if (cmd[`CMD_TX_ON]) tx_on_reg <= 1'b1;
         else if (cts_hold_reg && !TX_CHAR_BUSY) tx_on_reg <= 1'b0;
         cts_hold_reg <= (opmode == `OPMODE_MODEM) && CTS && tx_on_reg;
         if (cmd[`CMD_RTS_OFF]) rts_cmd_reg <= 1'b1;
         else if (cmd[`CMD_RTS_ON]) rts_cmd_reg <= 1'b0;
         if (cmd[`CMD_DTR_OFF]) DTR <= 1'b1;
         else if (cmd[`CMD_DTR_ON]) DTR <= 1'b0;
         if (cmd[`CMD_SEND_ADDR] && multidrop) ADDR_PENDING <= 1'b1;
         else if (wr && PADDR == `OFF_TX_HOLDING) ADDR_PENDING <= 1'b0;
      end
   end

   // -------------------------------------------------------------------------
   // Engine enables, forced off in remote loopback
   // -------------------------------------------------------------------------
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         RX_ENABLE <= 1'b0;
         TX_ENABLE <= 1'b0;
      end else begin
         RX_ENABLE <= rx_on_reg && channel_mode_field != `CHANNEL_MODE_FIELD_REMOTE;
         TX_ENABLE <= tx_on_reg && channel_mode_field != `CHANNEL_MODE_FIELD_REMOTE;
      end
   end

   // -------------------------------------------------------------------------
   // Break sequencer: idle, wait drain, break, high tail
   // -------------------------------------------------------------------------
   localparam BRK_IDLE = 2'd0;
   localparam BRK_WAIT = 2'd1;
   localparam BRK_ON = 2'd2;
   localparam BRK_TAIL = 2'd3;

   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         brk_state_reg <= BRK_IDLE;
         brk_count_reg <= 8'h00;
      end else begin
         if (BIT_TICK && brk_count_reg != 8'h00) brk_count_reg <= brk_count_reg - 8'h01;
         case (brk_state_reg)
            BRK_IDLE: if (cmd[`CMD_BRK_BEGIN]) brk_state_reg <= BRK_WAIT;
            BRK_WAIT: begin
               if (TX_EMPTY) begin
                  brk_state_reg <= BRK_ON;
                  brk_count_reg <= `BRK_MIN_BITS;
               end
            end
            BRK_ON: begin
               if ((cmd[`CMD_BRK_END] || brk_end_pending_reg) && brk_count_reg == 8'h00) begin
                  brk_state_reg <= BRK_TAIL;
                  brk_count_reg <= `BRK_TAIL_BITS;
               end
            end
            BRK_TAIL: begin
               if (brk_count_reg == 8'h00) brk_state_reg <= BRK_IDLE;
            end
            default: brk_state_reg <= BRK_IDLE;
         endcase
      end
   end

   // Break end before the minimum length is latched and honoured when it expires
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         brk_end_pending_reg <= 1'b0;
         BREAK_ACTIVE <= 1'b0;
      end else begin
         BREAK_ACTIVE <= (brk_state_reg == BRK_ON);
         if (brk_state_reg != BRK_ON) brk_end_pending_reg <= 1'b0;
         else if (cmd[`CMD_BRK_END] && brk_count_reg != 8'h00) brk_end_pending_reg <= 1'b1;
      end
   end

   // -------------------------------------------------------------------------
   // Infrared demodulator and channel routing
   // -------------------------------------------------------------------------
   ir_rx_filter u_ir (
      .clk(CLK),
      .resetn(RESETN),
      .enable(opmode == `OPMODE_INFRARED),
      .filter_value(filter_reg),
      .rx_pin(RXD),
      .bit_tick(BIT_TICK),
      .rx_out(ir_rx)
   );

   wire rx_src = (opmode == `OPMODE_INFRARED) ? ir_rx : RXD;
   wire brk_tail = (brk_state_reg == BRK_TAIL);
   wire tx_line = (TX_SERIAL | brk_tail) & ~BREAK_ACTIVE;

   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         TXD <= 1'b1;
         RX_SERIAL <= 1'b1;
         RTS <= 1'b1;
      end else begin
         case (channel_mode_field)
            `CHANNEL_MODE_FIELD_ECHO: begin
               TXD <= RXD;
               RX_SERIAL <= rx_src;
            end
            `CHANNEL_MODE_FIELD_LOCAL: begin
               TXD <= 1'b1;
               RX_SERIAL <= tx_line;
            end
            `CHANNEL_MODE_FIELD_REMOTE: begin
               TXD <= RXD;
               RX_SERIAL <= 1'b1;
            end
            default: begin
               TXD <= tx_line;
               RX_SERIAL <= rx_src;
            end
         endcase
         if (opmode == `OPMODE_RS485) RTS <= ~TX_EMPTY | TIMEGUARD_BUSY;
         else RTS <= rts_cmd_reg;
      end
   end
endmodule // usart_line_modes_ctrl

// file: line_modes_properties.sv
// Port-level checks of the line-mode block
`timescale 1ns/10ps
module line_modes_checker (
   input wire CLK, // Clock
   input wire RESETN, // Reset, low
   input wire PSEL, // Select
   input wire PENABLE, // Access
   input wire PWRITE, // Write
   input wire [11:0] PADDR, // Address
   input wire [31:0] PWDATA, // Data
   input wire RXD, // Rx pin
   input wire TXD, // Tx pin
   input wire RTS, // Rts pin
   input wire DTR, // Dtr pin
   input wire TX_SERIAL, // Tx engine
   input wire TX_EMPTY, // Tx empty
   input wire TIMEGUARD_BUSY, // Timeguard
   input wire RX_SERIAL, // Rx engine
   input wire RX_ENABLE, // Rx on
   input wire [31:0] MODE_OUT // Mode
);
// ----
// Checks
// ----
wire cmd_wr = PSEL && PENABLE && PWRITE && PADDR == 12'h000;
wire [1:0] chm = MODE_OUT[15:14];
wire plain = MODE_OUT[3:0] != 4'h8;
default clocking cb @(posedge CLK);
endclocking
default disable iff (!RESETN);
chk_dtr_low: assert property (
   cmd_wr && PWDATA[16] && !PWDATA[17] |-> ##[1:2] !DTR) else $error("DTR not low");
chk_dtr_high: assert property (
   cmd_wr && PWDATA[17] |-> ##[1:2] DTR) else $error("DTR not high");
chk_rts_line: assert property (
   MODE_OUT[3:0] == 4'h1 && $past(MODE_OUT[3:0]) == 4'h1
   |-> RTS == (!$past(TX_EMPTY) || $past(TIMEGUARD_BUSY))) else $error("RTS wrong");
chk_rx_direct: assert property (
   chm < 2'h2 && $past(chm) < 2'h2 && plain && $past(plain)
   |-> RX_SERIAL == $past(RXD)) else $error("Rx input wrong");
chk_echo_path: assert property (
   chm == 2'h1 && $past(chm) == 2'h1 |-> TXD == $past(RXD)) else $error("Echo wrong");
chk_local_loop: assert property (
   chm == 2'h2 && $past(chm) == 2'h2 && plain && $past(plain)
   |-> TXD && RX_SERIAL == $past(TX_SERIAL)) else $error("Local loop wrong");
chk_remote_loop: assert property (
   chm == 2'h3 && $past(chm) == 2'h3 |-> TXD == $past(RXD) && RX_SERIAL && !RX_ENABLE)
   else $error("Remote loop wrong");
chk_enable_veto: assert property (
   cmd_wr && PWDATA[4] && PWDATA[5] |-> ##2 !RX_ENABLE) else $error("Rx on despite off");
endmodule // line_modes_checker
bind usart_line_modes_ctrl line_modes_checker chk (.*);

// file: line_far_end.sv
// Far-end model: receive line and modem status lines
`timescale 1ns/10ps
module line_far_end (
   input wire clk, // Clock
   input wire rx_cmd, // Line level asked
   input wire [3:0] ctl_cmd, // Levels cts,dcd,dsr,ri
   output reg rxd, // Receive line
   output reg ri, // Ring
   output reg dsr, // Set ready
   output reg dcd, // Carrier
   output reg cts // Clear to send
);
initial begin
   rxd = 1'b1;
   {cts, dcd, dsr, ri} = 4'hf;
end
always @(posedge clk) begin
   rxd <= rx_cmd;
   {cts, dcd, dsr, ri} <= ctl_cmd;
end
endmodule // line_far_end

// file: testbench.sv
// Self-checking bench of the line-mode block
`timescale 1ns/10ps
module testbench;
reg CLK = 1'b0, RESETN = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, BIT_TICK = 1'b0;
reg TX_SERIAL = 1'b1, TX_EMPTY = 1'b1, TX_CHAR_BUSY = 1'b0, TIMEGUARD_BUSY = 1'b0, rx_cmd = 1'b1;
reg [3:0] ctl_cmd = 4'hf, tk = 4'h0;
reg [4:0] LINE_EVENTS = 5'h00;
reg [11:0] PADDR = 12'h000, a;
reg [31:0] PWDATA = 32'h0, rnd = 32'hffa7, m, exp_q[$], msk_q[$];
wire [31:0] PRDATA, MODE_OUT;
wire PREADY, PSLVERR, RXD, TXD, RTS, DTR, CTS, DSR, DCD, RI, RX_SERIAL, RX_ENABLE, TX_ENABLE;
wire BREAK_ACTIVE, ADDR_PENDING;
integer n_fail = 0, checks_done = 0, i;
localparam [59:0] RA = {12'h04c, 12'h040, 12'h028, 12'h024, 12'h020};
localparam [79:0] MS = {16'h00ff, 16'h07ff, 16'h00ff, 16'hffff, 16'hffff};
localparam [47:0] LA = {12'h018, 12'h010, 12'h02c, 12'h000};
usart_line_modes_ctrl DUT (.*, .RX_RESET(), .TX_RESET(), .TO_START(), .TO_REARM(),
   .NACK_CLEAR(), .BAUD_OUT(), .TIMEOUT_OUT(), .TIMEGUARD_OUT(), .RATIO_OUT());
line_far_end FAR (.clk(CLK), .rx_cmd(rx_cmd), .ctl_cmd(ctl_cmd), .rxd(RXD), .ri(RI),
   .dsr(DSR), .dcd(DCD), .cts(CTS));
always #5 CLK = ~CLK;
always @(posedge CLK) begin
   tk <= tk + 4'h1;
   BIT_TICK <= tk == 4'hf;
end
// ----
// Tasks
// ----
function [31:0] xs(input [31:0] v);
   reg [31:0] t;
   begin
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
   end
endfunction
task cmp(input string nm, input [31:0] got, input [31:0] exp);
   begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
         n_fail = n_fail + 1;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   end
endtask
task apb(input w, input [11:0] ad, input [31:0] d, input [31:0] mk);
   begin
      if (!w) begin
         exp_q.push_back(d & mk);
         msk_q.push_back(mk);
      end
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= ad;
      PWDATA <= w ? d : 32'h0;
      @(posedge CLK);
      PENABLE <= 1'b1;
      @(posedge CLK);
      while (PREADY !== 1'b1) @(posedge CLK);
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   end
endtask
task wt(input integer n);
   begin
      repeat (n) @(posedge CLK);
      @(negedge CLK);
   end
endtask
task final_report;
   begin
      $display("Checks %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   end
endtask
always @(posedge CLK)
   if (PSEL && PENABLE && !PWRITE && PREADY === 1'b1 && exp_q.size() > 0)
      cmp("PRDATA", PRDATA & msk_q.pop_front(), exp_q.pop_front());
initial begin
   #300000;
   n_fail = n_fail + 1;
   final_report;
end
// ----
// Scenarios
// ----
initial begin
   repeat (12) @(posedge CLK);
   RESETN <= 1'b1;
   for (i = 0; i < 5; i = i + 1) begin
      a = RA[12*i +: 12];
      m = {16'h0, MS[16*i +: 16]};
      apb(1'b0, a, (i == 3) ? 32'h174 : 32'h0, m);
      rnd = xs(rnd);
      apb(1'b1, a, rnd, 32'h0);
      apb(1'b0, a, rnd, m);
   end
   for (i = 0; i < 4; i = i + 1)
      apb(1'b0, LA[12*i +: 12], 32'h0, 32'hffffffff);
   $display("Done: register map");
   for (i = 0; i < 4; i = i + 1) begin
      apb(1'b1, 12'h000, (i[0] ? 32'h30 : 32'h10) << (2 * i[1]), 32'h0);
      wt(2);
      cmp("enable", i[1] ? TX_ENABLE : RX_ENABLE, !i[0]);
      apb(1'b1, 12'h000, 32'h10000 << i, 32'h0);
      wt(2);
      cmp("modem output", i[1] ? RTS : DTR, i[0]);
   end
   @(posedge CLK) LINE_EVENTS <= 5'h1f;
   @(posedge CLK) LINE_EVENTS <= 5'h00;
   apb(1'b0, 12'h014, 32'h4e4, 32'h4e4);
   apb(1'b1, 12'h000, 32'h2100, 32'h0);
   apb(1'b0, 12'h014, 32'h400, 32'h4e4);
   apb(1'b1, 12'h004, 32'h4, 32'h0);
   apb(1'b1, 12'h000, 32'h3000, 32'h0);
   apb(1'b0, 12'h014, 32'h0, 32'h400);
   wt(2);
   cmp("address flag", ADDR_PENDING, 1'b0);
   apb(1'b1, 12'h004, 32'he00, 32'h0);
   apb(1'b1, 12'h000, 32'h1000, 32'h0);
   wt(2);
   cmp("address flag", ADDR_PENDING, 1'b1);
   apb(1'b1, 12'h01c, 32'h55, 32'h0);
   wt(2);
   cmp("address flag", ADDR_PENDING, 1'b0);
   apb(1'b1, 12'h004, 32'h0, 32'h0);
   @(posedge CLK) TX_EMPTY <= 1'b0;
   apb(1'b1, 12'h000, 32'h200, 32'h0);
   wt(4);
   cmp("break", BREAK_ACTIVE, 1'b0);
   @(posedge CLK) TX_EMPTY <= 1'b1;
   wt(4);
   cmp("break", {BREAK_ACTIVE, TXD}, 2'b10);
   apb(1'b1, 12'h000, 32'h400, 32'h0);
   wt(100);
   cmp("break", BREAK_ACTIVE, 1'b1);
   wt(420);
   cmp("break", {BREAK_ACTIVE, TXD}, 2'b01);
   $display("Done: commands");
   apb(1'b1, 12'h004, 32'h3, 32'h0);
   @(posedge CLK) ctl_cmd <= 4'h0;
   apb(1'b1, 12'h000, 32'h40, 32'h0);
   apb(1'b0, 12'h014, 32'h0, 32'h0);
   @(posedge CLK) TX_CHAR_BUSY <= 1'b1;
   @(posedge CLK) ctl_cmd <= 4'hf;
   wt(4);
   cmp("transmitter", TX_ENABLE, 1'b1);
   apb(1'b0, 12'h014, 32'h00ff0000, 32'h00ff0000);
   apb(1'b0, 12'h014, 32'h00f00000, 32'h00ff0000);
   @(posedge CLK) TX_CHAR_BUSY <= 1'b0;
   wt(4);
   cmp("transmitter", TX_ENABLE, 1'b0);
   @(posedge CLK) ctl_cmd <= 4'h0;
   $display("Done: modem");
   for (i = 0; i < 4; i = i + 1) begin
      apb(1'b1, 12'h004, (i << 14) | 1, 32'h0);
      repeat (40) @(posedge CLK) begin
         rnd = xs(rnd);
         rx_cmd <= rnd[0];
         TX_SERIAL <= rnd[1];
         TX_EMPTY <= rnd[2];
         TIMEGUARD_BUSY <= rnd[3] & rnd[4];
      end
   end
   @(posedge CLK) rx_cmd <= 1'b1;
   TX_EMPTY <= 1'b1;
   TIMEGUARD_BUSY <= 1'b0;
   apb(1'b1, 12'h040, 32'h1, 32'h0);
   apb(1'b1, 12'h04c, 32'h4, 32'h0);
   apb(1'b1, 12'h004, 32'h8, 32'h0);
   @(posedge CLK) rx_cmd <= 1'b0;
   @(posedge CLK);
   @(posedge CLK) rx_cmd <= 1'b1;
   wt(12);
   cmp("receiver input", RX_SERIAL, 1'b1);
   @(posedge CLK iff BIT_TICK) rx_cmd <= 1'b0;
   wt(12);
   cmp("receiver input", RX_SERIAL, 1'b0);
   @(posedge CLK) rx_cmd <= 1'b1;
   wt(24);
   cmp("receiver input", RX_SERIAL, 1'b1);
   $display("Done: line modes");
   final_report;
end
endmodule // testbench
